// ---- design/spfa_top.sv ----
/*
 Self-program flash access sequencer with an APB register slave, write latches and row timer.
 Assumes one clock pclk, APB master per protocol, configuration bits as static inputs.
*/
// Operation
// - Data pair is 14 bits, address 15
// - High address byte and low byte combine
// - Start bits set-only, hardware clears them
// - Writes need program enable, cleared at reset
// - Reset during write sets program error
// - Unlock register reads as zero
// - Latch load and program need unlock pattern
// - Rows of 32 words, row erase smallest
// - 32 latches of 14 bits, sequential
// - Blank words programmable without erase
// - Read uses second cycle, data next
// - Data pair holds until read or write
// - Code guard low blocks external access
// - Only external bulk erase removes guard; here a reset also reloads it from code_guard
// - Lock bits block self-write in regions
// - Internal timer times each row operation
// - Low five bits latch, upper ten row
// - Latches return to 3FFF after program
// - Row operation stalls, latch load does not
`timescale 1ns/1ns
`include "spfa_map.svh"
module spfa_top
	import spfa_pkg::*;
#(
	parameter int ROW_CYCLES = `SPFA_ROW_CYCLES,
	parameter int ROWS       = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        code_guard,
	input  wire logic [1:0]  memory_lock_bits,
	input  wire logic        ext_bulk_erase,
	output logic             cpu_stall,
	output logic             guard_active
);
	typedef struct packed {
		spfa_state_t              state;
		spfa_key_t                key;
		logic [7:0]               addr_low;
		logic [6:0]               addr_high;
		logic [7:0]               data_low;
		logic [5:0]               data_high;
		logic                     fetch;
		logic                     prog;
		logic                     enable;
		logic                     error;
		logic                     erase;
		logic                     latch_only;
		logic                     cfg_sel;
		logic [1:0]               nops;
		logic [31:0]              timer;
		logic [`SPFA_WORDS*14-1:0] latches;
		logic                     row_write;
		logic                     row_erase;
		logic                     stall;
		logic                     guard;
		logic                     guard_init;
		logic [31:0]              rdata;
		logic                     ready;
		logic                     slverr;
	} spfa_regs_t;
	spfa_regs_t r;
	spfa_regs_t next_r;
	logic [14:0] word_addr;
	logic [13:0] rd_word;
	logic        wr_xfer;
	logic        rd_xfer;
	logic        locked;
	// Error flag lives in a register that a reset pulse cannot clear while a write is running
	logic        err_keep;
	logic        err_clear;
	assign word_addr = {r.addr_high, r.addr_low};
	assign err_clear = wr_xfer && paddr == `SPFA_OFS_CONTROL && !pwdata[`SPFA_BIT_ERROR] && !r.stall;
	assign wr_xfer   = psel && penable && !r.ready && pwrite;
	assign rd_xfer   = psel && penable && !r.ready && !pwrite;
	// Lock bits 01 protect the lower half, 10 the lower quarter, 00 all, 11 none
	always_comb begin
		unique case (memory_lock_bits)
			2'h0:    locked = 1'b1;
			2'h1:    locked = !word_addr[14];
			2'h2:    locked = word_addr[14:13] == 2'h0;
			default: locked = 1'b0;
		endcase
	end
	spfa_array #(
		.ROWS(ROWS)
	) u_array (
		.pclk      (pclk),
		.presetn   (presetn),
		.row_sel   (word_addr[5 +: $clog2(ROWS)]),
		.word_sel  (word_addr[4:0]),
		.rd_word   (rd_word),
		.row_write (r.row_write),
		.row_data  (r.latches),
		.row_erase (r.row_erase)
	);
	always_comb begin
		next_r           = r;
		next_r.ready     = 1'b0;
		next_r.slverr    = 1'b0;
		next_r.row_write = 1'b0;
		next_r.row_erase = 1'b0;
		if (!r.guard_init) begin
			next_r.guard      = !code_guard;
			next_r.guard_init = 1'b1;
		end
		if (ext_bulk_erase) begin
			next_r.guard = 1'b0;
		end
		if (psel && penable && !r.ready) begin
			next_r.ready = 1'b1;
			next_r.rdata = 32'h0000_0000;
			if (r.stall) begin
				next_r.ready = 1'b0;
			end else if (pwrite) begin
				unique case (paddr)
					`SPFA_OFS_ADDR_LOW:  next_r.addr_low = pwdata[7:0];
					`SPFA_OFS_ADDR_HIGH: next_r.addr_high = pwdata[`SPFA_ADDR_HIGH_W-1:0];
					`SPFA_OFS_DATA_LOW:  next_r.data_low = pwdata[7:0];
					`SPFA_OFS_DATA_HIGH: next_r.data_high = pwdata[5:0];
					`SPFA_OFS_CONTROL: begin
						next_r.fetch      = r.fetch | pwdata[`SPFA_BIT_FETCH];
						next_r.prog       = r.prog | pwdata[`SPFA_BIT_PROG];
						next_r.enable     = pwdata[`SPFA_BIT_ENABLE];
						next_r.error      = pwdata[`SPFA_BIT_ERROR];
						next_r.erase      = pwdata[`SPFA_BIT_ERASE];
						next_r.latch_only = pwdata[`SPFA_BIT_LATCH_ONLY];
						next_r.cfg_sel    = pwdata[`SPFA_BIT_CFG_SEL];
					end
					`SPFA_OFS_UNLOCK: begin
						if (pwdata[7:0] == `SPFA_KEY_FIRST) begin
							next_r.key = SPFA_KEY_HALF;
						end else if (pwdata[7:0] == `SPFA_KEY_SECOND && r.key == SPFA_KEY_HALF) begin
							next_r.key = SPFA_KEY_FULL;
						end else begin
							next_r.key = SPFA_KEY_NONE;
						end
					end
					`SPFA_OFS_CONFIG, `SPFA_OFS_STALL: next_r.slverr = 1'b0;
					default: next_r.slverr = 1'b1;
				endcase
				// Any write other than the key pair or a control write breaks the sequence
				if (paddr != `SPFA_OFS_UNLOCK && paddr != `SPFA_OFS_CONTROL) begin
					next_r.key = SPFA_KEY_NONE;
				end
			end else begin
				unique case (paddr)
					`SPFA_OFS_ADDR_LOW:  next_r.rdata = {24'h000000, r.addr_low};
					`SPFA_OFS_ADDR_HIGH: next_r.rdata = {25'h0000000, r.addr_high};
					`SPFA_OFS_DATA_LOW:  next_r.rdata = {24'h000000, r.data_low};
					`SPFA_OFS_DATA_HIGH: next_r.rdata = {26'h0000000, r.data_high};
					`SPFA_OFS_CONTROL:   next_r.rdata = {25'h0000000, r.cfg_sel, r.latch_only, r.erase,
					                                     r.error | err_keep, r.enable, r.prog, r.fetch};
					`SPFA_OFS_UNLOCK:    next_r.rdata = 32'h0000_0000;
					`SPFA_OFS_CONFIG:    next_r.rdata = {29'h00000000, memory_lock_bits, r.guard};
					`SPFA_OFS_STALL:     next_r.rdata = {31'h00000000, r.stall};
					default:             next_r.slverr = 1'b1;
				endcase
			end
		end
		unique case (r.state)
			SPFA_IDLE: begin
				if (r.fetch) begin
					next_r.state = SPFA_FETCH;
				end else if (r.prog) begin
					if (!r.enable || r.key != SPFA_KEY_FULL || r.cfg_sel || locked) begin
						next_r.prog = 1'b0;
					end else begin
						next_r.state = SPFA_NOPS;
						next_r.nops  = `SPFA_FORCED_NOPS;
					end
					next_r.key = SPFA_KEY_NONE;
				end
			end
			SPFA_FETCH: begin
				// Second cycle after the start does the array read; data appears next
				next_r.data_low  = rd_word[7:0];
				next_r.data_high = rd_word[13:8];
				next_r.fetch     = 1'b0;
				next_r.state     = SPFA_IDLE;
			end
			SPFA_NOPS: begin
				next_r.nops = r.nops - 2'h1;
				if (r.nops == 2'h1) begin
					if (r.latch_only && !r.erase) begin
						// Low five address bits pick the latch
						next_r.latches[word_addr[4:0]*14 +: 14] = {r.data_high, r.data_low};
						next_r.state = SPFA_FINISH;
					end else begin
						next_r.stall = 1'b1;
						next_r.timer = 32'(ROW_CYCLES);
						next_r.state = SPFA_BUSY;
					end
				end
			end
			SPFA_BUSY: begin
				next_r.timer = r.timer - 32'h1;
				if (r.timer == 32'h1) begin
					next_r.row_erase = r.erase;
					next_r.row_write = !r.erase;
					next_r.state     = SPFA_FINISH;
				end
			end
			SPFA_FINISH: begin
				if (!r.latch_only && !r.erase) begin
					next_r.latches = {`SPFA_WORDS{`SPFA_LATCH_BLANK}};
				end
				next_r.stall = 1'b0;
				next_r.prog  = 1'b0;
				next_r.state = SPFA_IDLE;
			end
			default: next_r.state = SPFA_IDLE;
		endcase
	end
	// Marks a row operation in flight in step with the stall flag, but without its reset
	logic err_pending;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{state: SPFA_IDLE, key: SPFA_KEY_NONE, latches: {`SPFA_WORDS{`SPFA_LATCH_BLANK}},
			       default: '0};
		end else begin
			r <= next_r;
		end
	end
	// No reset here: a reset that drops the stall while the mark still stands sets the error
	// Both flops power up unknown; software clears the error bit once after power-up
	always_ff @(posedge pclk) begin
		err_pending <= next_r.stall;
		err_keep    <= (err_pending && !r.stall) || (err_keep && !err_clear);
	end
	a_error_kept: assert property (@(posedge pclk)
		err_pending && !r.stall |=> err_keep) else $error("cut write not flagged");
	assign prdata       = r.rdata;
	assign pready       = r.ready;
	assign pslverr      = r.slverr;
	assign cpu_stall    = r.stall;
	assign guard_active = r.guard;
	a_fetch_clears: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_FETCH |=> !r.fetch && r.state == SPFA_IDLE) else $error("fetch bit not cleared");
	a_fetch_data: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_FETCH |=> {r.data_high, r.data_low} == $past(rd_word)) else $error("fetch data wrong");
	a_unlock_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd_xfer && paddr == `SPFA_OFS_UNLOCK && !r.stall |=> prdata == 32'h0) else $error("unlock read nonzero");
	a_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_IDLE && !r.fetch && r.prog && !r.enable |=> !r.prog && r.state == SPFA_IDLE)
		else $error("start without enable");
	a_need_key: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_IDLE && !r.fetch && r.prog && r.key != SPFA_KEY_FULL |=> r.state == SPFA_IDLE)
		else $error("start without key");
	a_blank_latch: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_FINISH && !r.latch_only && !r.erase |=> r.latches == {`SPFA_WORDS{`SPFA_LATCH_BLANK}})
		else $error("latches not blank");
	a_load_nostall: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_NOPS && r.latch_only && !r.erase |-> !r.stall) else $error("latch load stalled");
	a_stall_busy: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_BUSY |-> cpu_stall) else $error("busy without stall");
	a_locked_row: assert property (@(posedge pclk) disable iff (!presetn)
		r.state == SPFA_IDLE && !r.fetch && r.prog && locked |=> r.state == SPFA_IDLE) else $error("lock ignored");
	c_fetch: cover property (@(posedge pclk) disable iff (!presetn) r.state == SPFA_FETCH);
	c_load: cover property (@(posedge pclk) disable iff (!presetn) r.state == SPFA_NOPS && r.latch_only);
	c_row: cover property (@(posedge pclk) disable iff (!presetn) r.row_write);
	c_erase: cover property (@(posedge pclk) disable iff (!presetn) r.row_erase);
endmodule

// ---- include/spfa_map.svh ----
/*
 Register offsets, field positions, reset values and timing counts for the self-program flash access block.
 Assumes inclusion by bare name from the design and bench files.
*/
`ifndef SPFA_MAP_SVH
`define SPFA_MAP_SVH
`define SPFA_OFS_ADDR_LOW   12'h000
`define SPFA_OFS_ADDR_HIGH  12'h004
`define SPFA_OFS_DATA_LOW   12'h008
`define SPFA_OFS_DATA_HIGH  12'h00C
`define SPFA_OFS_CONTROL    12'h010
`define SPFA_OFS_UNLOCK     12'h014
`define SPFA_OFS_CONFIG     12'h018
`define SPFA_OFS_STALL      12'h01C
`define SPFA_BIT_FETCH      0
`define SPFA_BIT_PROG       1
`define SPFA_BIT_ENABLE     2
`define SPFA_BIT_ERROR      3
`define SPFA_BIT_ERASE      4
`define SPFA_BIT_LATCH_ONLY 5
`define SPFA_BIT_CFG_SEL    6
`define SPFA_BIT_GUARD      0
`define SPFA_LOCK_LO        1
`define SPFA_LOCK_HI        2
`define SPFA_KEY_FIRST      8'h55
`define SPFA_KEY_SECOND     8'hAA
`define SPFA_LATCH_BLANK    14'h3FFF
`define SPFA_WORDS          32
`define SPFA_ROW_MS         2
`define SPFA_CLK_MHZ        100
`define SPFA_ROW_CYCLES     (`SPFA_ROW_MS * 1000 * `SPFA_CLK_MHZ)
`define SPFA_FORCED_NOPS    2'h2
`define SPFA_ADDR_HIGH_W    7
`endif

// ---- include/spfa_pkg.sv ----
/*
 Types for the self-program flash access block.
 Assumes spfa_map.svh is on the include path.
*/
package spfa_pkg;
	typedef enum logic [4:0] {
		SPFA_IDLE   = 5'h01,
		SPFA_FETCH  = 5'h02,
		SPFA_NOPS   = 5'h04,
		SPFA_BUSY   = 5'h08,
		SPFA_FINISH = 5'h10
	} spfa_state_t;
	typedef enum logic [1:0] {
		SPFA_KEY_NONE = 2'h0,
		SPFA_KEY_HALF = 2'h1,
		SPFA_KEY_FULL = 2'h2
	} spfa_key_t;
endpackage

// ---- design/spfa_array.sv ----
/*
 Flash word array model held in flip-flops: one read port, one row write port, one row erase port.
 Assumes the sequencer writes only inside one row per operation and never reads and writes in one cycle.
*/
`timescale 1ns/1ns
`include "spfa_map.svh"
module spfa_array
	import spfa_pkg::*;
#(
	parameter int ROWS = 4
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [$clog2(ROWS)-1:0]    row_sel,
	input  wire logic [4:0]                 word_sel,
	output logic      [13:0]                rd_word,
	input  wire logic                       row_write,
	input  wire logic [`SPFA_WORDS*14-1:0]  row_data,
	input  wire logic                       row_erase
);
	logic [13:0] mem [ROWS*`SPFA_WORDS];
	assign rd_word = mem[{row_sel, word_sel}];
	// Programming can only clear bits, so blank words take new data without an erase
	for (genvar g = 0; g < ROWS*`SPFA_WORDS; g++) begin : g_word
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem[g] <= `SPFA_LATCH_BLANK;
			end else if (row_erase && row_sel == g / `SPFA_WORDS) begin
				mem[g] <= `SPFA_LATCH_BLANK;
			end else if (row_write && row_sel == g / `SPFA_WORDS) begin
				mem[g] <= mem[g] & row_data[(g % `SPFA_WORDS)*14 +: 14];
			end
		end
	end
endmodule

// ---- testbench/spfa_cpu_model.sv ----
/*
 Processor-side model: issues register reads and writes as an APB master.
 Assumes one clock shared with the block; the bench calls xfer by hierarchy.
*/
`timescale 1ns/1ns
module spfa_cpu_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// Request held until pready is sampled high; the watchdog ends a hang
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- testbench/spfa_top_bench.sv ----
/*
 Self-checking bench for the flash access block: reads, latch loads, row programs, refusals.
 Assumes spfa_map.svh on the include path and a short row timer.
*/
`timescale 1ns/1ns
`include "spfa_map.svh"
module spfa_top_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
	logic        code_guard, ext_bulk_erase, cpu_stall, guard_active;
	logic [1:0]  memory_lock_bits;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	int          n_mismatch, tests_run;
	localparam logic [31:0] PROG = 32'h1 << `SPFA_BIT_PROG | 32'h1 << `SPFA_BIT_ENABLE;
	localparam logic [31:0] LOAD = PROG | 32'h1 << `SPFA_BIT_LATCH_ONLY;
	localparam logic [31:0] NO_EN = LOAD & ~(32'h1 << `SPFA_BIT_ENABLE);
	spfa_top #(.ROW_CYCLES(20), .ROWS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .code_guard(code_guard),
		.memory_lock_bits(memory_lock_bits), .ext_bulk_erase(ext_bulk_erase),
		.cpu_stall(cpu_stall), .guard_active(guard_active));
	spfa_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		cpu.xfer(1'b1, a, d, rd_v, err_v);
	endtask
	task automatic rd(input logic [11:0] a);
		cpu.xfer(1'b0, a, 32'h0, rd_v, err_v);
	endtask
	task automatic set_addr(input logic [14:0] a);
		wr(`SPFA_OFS_ADDR_LOW, {24'h0, a[7:0]});
		wr(`SPFA_OFS_ADDR_HIGH, {25'h0, a[14:8]});
	endtask
	task automatic key();
		wr(`SPFA_OFS_UNLOCK, {24'h0, `SPFA_KEY_FIRST});
		wr(`SPFA_OFS_UNLOCK, {24'h0, `SPFA_KEY_SECOND});
	endtask
	task automatic fetch(input logic [14:0] a, input logic [13:0] exp);
		logic [7:0] lo;
		set_addr(a);
		wr(`SPFA_OFS_CONTROL, 32'h1 << `SPFA_BIT_FETCH);
		repeat (3) @(posedge pclk);
		rd(`SPFA_OFS_DATA_LOW);
		lo = rd_v[7:0];
		rd(`SPFA_OFS_DATA_HIGH);
		check({18'h0, rd_v[5:0], lo}, {18'h0, exp}, "flash word");
		rd(`SPFA_OFS_CONTROL);
		check({31'h0, rd_v[`SPFA_BIT_FETCH]}, 32'h0, "fetch bit");
	endtask
	task automatic load(input logic [14:0] a, input logic [13:0] d, input logic unlock, input logic [31:0] ctl);
		set_addr(a);
		wr(`SPFA_OFS_DATA_LOW, {24'h0, d[7:0]});
		wr(`SPFA_OFS_DATA_HIGH, {26'h0, d[13:8]});
		if (unlock)
			key();
		wr(`SPFA_OFS_CONTROL, ctl);
		repeat (4) @(posedge pclk);
	endtask
	task automatic row_prog(input logic [14:0] a, input logic stalls);
		int cnt;
		cnt = 0;
		set_addr(a);
		key();
		wr(`SPFA_OFS_CONTROL, PROG);
		repeat (60) begin
			@(posedge pclk);
			if (cpu_stall === 1'b1)
				cnt++;
		end
		check({31'h0, cnt >= 20}, {31'h0, stalls}, "row stall");
		rd(`SPFA_OFS_CONTROL);
		check({31'h0, rd_v[`SPFA_BIT_PROG]}, 32'h0, "program bit");
	endtask
	task automatic t_reset();
		wr(`SPFA_OFS_CONTROL, 32'h0);
		rd(`SPFA_OFS_CONTROL);
		check(rd_v, 32'h0, "control after reset");
		wr(`SPFA_OFS_UNLOCK, {24'h0, `SPFA_KEY_FIRST});
		rd(`SPFA_OFS_UNLOCK);
		check(rd_v, 32'h0, "unlock readback");
		rd(12'h020);
		check({31'h0, err_v}, 32'h1, "unmapped offset");
		$display("test reset done");
	endtask
	task automatic t_read();
		fetch(15'h0021, `SPFA_LATCH_BLANK);
		wr(`SPFA_OFS_DATA_LOW, 32'h5A);
		rd(`SPFA_OFS_DATA_LOW);
		check({24'h0, rd_v[7:0]}, 32'h5A, "data pair hold");
		$display("test read done");
	endtask
	task automatic t_reject();
		load(15'h0021, 14'h0000, 1'b0, LOAD);
		load(15'h0022, 14'h0000, 1'b1, NO_EN);
		rd(`SPFA_OFS_CONTROL);
		check({31'h0, rd_v[`SPFA_BIT_PROG]}, 32'h0, "refused start");
		row_prog(15'h0020, 1'b1);
		fetch(15'h0021, `SPFA_LATCH_BLANK);
		fetch(15'h0022, `SPFA_LATCH_BLANK);
		$display("test reject done");
	endtask
	task automatic t_program();
		load(15'h0021, 14'h1234, 1'b1, LOAD);
		load(15'h0022, 14'h0ABC, 1'b1, LOAD);
		row_prog(15'h0020, 1'b1);
		fetch(15'h0021, 14'h1234);
		fetch(15'h0022, 14'h0ABC);
		fetch(15'h0020, `SPFA_LATCH_BLANK);
		row_prog(15'h0040, 1'b1);
		fetch(15'h0041, `SPFA_LATCH_BLANK);
		$display("test program done");
	endtask
	task automatic t_lock();
		memory_lock_bits <= 2'b00;
		load(15'h0061, 14'h0000, 1'b1, LOAD);
		row_prog(15'h0060, 1'b0);
		fetch(15'h0061, `SPFA_LATCH_BLANK);
		memory_lock_bits <= 2'b11;
		$display("test lock done");
	endtask
	task automatic t_reset_err();
		code_guard <= 1'b0;
		set_addr(15'h0000);
		key();
		wr(`SPFA_OFS_CONTROL, PROG);
		repeat (8) @(posedge pclk);
		check({31'h0, cpu_stall}, 32'h1, "stalled");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(`SPFA_OFS_CONTROL);
		check({31'h0, rd_v[`SPFA_BIT_ERROR]}, 32'h1, "error after reset");
		check({31'h0, guard_active}, 32'h1, "guard on");
		ext_bulk_erase <= 1'b1;
		repeat (3) @(posedge pclk);
		check({31'h0, guard_active}, 32'h0, "guard removed");
		ext_bulk_erase <= 1'b0;
		$display("test reset error done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		presetn = 1'b0;
		code_guard = 1'b1;
		memory_lock_bits = 2'b11;
		ext_bulk_erase = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_read();
		t_reject();
		t_program();
		t_lock();
		t_reset_err();
		print_verdict();
	end
endmodule
